// *** hw/g1_hs_cfg.svh ***
`ifndef G1_HS_CFG_SVH
`define G1_HS_CFG_SVH

// Register byte offsets from the board base
`define CONFIG_OFS     5'h00
`define PORT_A_OFS     5'h06
`define PORT_B_OFS     5'h07

// Configuration word field positions
`define BIT_B_EN       10
`define BIT_A_EN       9
`define BIT_LRESET     8
`define BIT_REQ_INV    6
`define BIT_DBL_BUF    5
`define BIT_PULSE      4
`define BIT_TRAIL      3
`define BIT_ACK_INV    2
`define BIT_MAN_ACK    1
`define BIT_EXTRA_OUT  0

// Reset values
`define RDATA_RST      16'h0000
`define BYTE_RST       8'h00

// Timing: core clock period and acknowledge pulse width
`define CLK_PERIOD_NS  5
`define ACK_PULSE_NS   100
`define ACK_PULSE_CYC  ((`ACK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Pattern FIFO depth
`define FIFO_DEPTH     16

`endif

// *** hw/g1_hs_pkg.sv ***
`include "g1_hs_cfg.svh"

package g1_hs_pkg;

    // Stored configuration bits (bit 7 and the upper bits are not kept)
    typedef struct packed {
        logic port_b_handshake_enable;
        logic port_a_handshake_enable;
        logic group1_local_reset;
        logic group1_request_invert;
        logic port_a_double_buffer;
        logic group1_pulse_mode;
        logic group1_trailing_edge_select;
        logic group1_acknowledge_invert;
        logic group1_manual_acknowledge;
        logic extra_output_line;
    } cfg_t;

    // Handshake sequencer
    typedef enum logic [1:0] {
        HS_IDLE      = 2'b00,
        HS_ACK_LEVEL = 2'b01,
        HS_ACK_PULSE = 2'b10
    } hs_state_t;

    typedef logic [7:0] cnt_t;
    typedef logic [7:0] byte_t;

    // Host bus request, one cycle wide strobes
    typedef struct packed {
        logic [4:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } bus_req_t;

endpackage

// *** hw/hs_fifo.sv ***
`timescale 1ns/1ps

module hs_fifo
    import g1_hs_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_flush,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    // Pointers carry one wrap bit so full and empty stay distinct
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("hs_fifo depth must be a power of two, at least 2");
        end
        if (WIDTH < 1) begin : g_bad_width
            $error("hs_fifo width must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } fifo_st_t;

    fifo_st_t s;
    fifo_st_t next_s;
    logic     push;
    logic     pop;

    // Handshake flags straight from the pointers
    assign o_in_ready  = (s.wp - s.rp) != (AW+1)'(DEPTH);
    assign o_out_valid = s.wp != s.rp;
    assign o_out_data  = s.mem[s.rp[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = i_out_ready && o_out_valid;

    // Flush wins over any transfer in the same cycle
    always_comb begin
        next_s = s;
        if (i_flush) begin
            next_s.wp = '0;
            next_s.rp = '0;
        end else begin
            if (push) begin
                next_s.mem[s.wp[AW-1:0]] = i_in_data;
                next_s.wp = s.wp + 1'b1;
            end
            if (pop) begin
                next_s.rp = s.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// *** hw/group1_handshake_port_control.sv ***
// Functional notes
// - Port B enable bit puts port B under group one handshake control.
// - Port A enable bit puts port A under group one handshake control.
// - Setting then clearing the local reset bit resets the handshake logic.
// - Bit seven of the configuration word is ignored on write.
// - Request invert set means low request is active; clear means high.
// - Double-buffered output: writes fill first buffer, requests copy it to pins.
// - Single-buffered output: written data reaches the pins at once.
// - Double-buffered input: request latches pins; reads return the latch.
// - Single-buffered input: reads return the live pin values.
// - Pulse bit selects pulse handshaking; clear selects level handshaking.
// - In pulse mode the edge bit picks trailing, else leading edge.
// - Acknowledge invert set drives acknowledge low, clear drives it high.
// - Manual acknowledge bit directly sets or clears the acknowledge line; the code ORs it with the sequencer acknowledge.
// - Extra output bit drives the extra connector line directly.
// - Configuration word is a write-only 16-bit register at offset zero.
`timescale 1ns/1ps
`include "g1_hs_cfg.svh"

module group1_handshake_port_control
    import g1_hs_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic     i_core_clk,
    input  wire logic     i_rst_n,
    // Host bus
    input  wire bus_req_t i_bus,
    output logic [15:0]   o_bus_rdata,
    output logic          o_port_a_wr_ready,
    // Port directions
    input  wire logic     i_port_a_dir_out,
    input  wire logic     i_port_b_dir_out,
    // Port A connector pins
    input  wire byte_t    i_port_a_pins,
    output byte_t         o_port_a_pins,
    output logic          o_port_a_oe,
    // Port B connector pins
    input  wire byte_t    i_port_b_pins,
    output byte_t         o_port_b_pins,
    output logic          o_port_b_oe,
    // Handshake and extra lines
    input  wire logic     i_group1_request_line,
    output logic          o_group1_acknowledge_line,
    output logic          o_extra_output_line
);
    localparam cnt_t ACK_CYC = cnt_t'(`ACK_PULSE_CYC);

    generate
        if (`ACK_PULSE_CYC < 1 || `ACK_PULSE_CYC > 255) begin : g_bad_ack
            $error("acknowledge pulse count does not fit its counter");
        end
    endgenerate

    // All module state except the pattern FIFO in one record
    typedef struct packed {
        cfg_t        cfg;
        logic        req_s1;
        logic        req_s2;
        logic        req_prev;
        byte_t       pa_s1;
        byte_t       pa_s2;
        byte_t       pb_s1;
        byte_t       pb_s2;
        hs_state_t   hs;
        cnt_t        cnt;
        logic        ack;
        logic        ack_line;
        byte_t       pa_out;
        byte_t       pa_in;
        byte_t       pb_out;
        byte_t       pb_in;
        logic [15:0] rdata;
    } st_t;

    st_t   s;
    st_t   next_s;
    logic  req_act;
    logic  recog;
    logic  wr_cfg;
    logic  wr_pa;
    logic  wr_pb;
    logic  pa_dbl_out;
    logic  fifo_push;
    logic  fifo_pop;
    logic  fifo_valid;
    logic  fifo_ready;
    byte_t fifo_data;

    // Bit 7 and the upper delay/DMA/interrupt bits are dropped here
    function automatic cfg_t to_cfg(input logic [15:0] w);
        cfg_t c;
        c.port_b_handshake_enable     = w[`BIT_B_EN];
        c.port_a_handshake_enable     = w[`BIT_A_EN];
        c.group1_local_reset          = w[`BIT_LRESET];
        c.group1_request_invert       = w[`BIT_REQ_INV];
        c.port_a_double_buffer        = w[`BIT_DBL_BUF];
        c.group1_pulse_mode           = w[`BIT_PULSE];
        c.group1_trailing_edge_select = w[`BIT_TRAIL];
        c.group1_acknowledge_invert   = w[`BIT_ACK_INV];
        c.group1_manual_acknowledge   = w[`BIT_MAN_ACK];
        c.extra_output_line           = w[`BIT_EXTRA_OUT];
        return c;
    endfunction

    // Address decode; the configuration word has no read path
    assign wr_cfg = i_bus.wr && i_bus.addr == `CONFIG_OFS;
    assign wr_pa  = i_bus.wr && i_bus.addr == `PORT_A_OFS;
    assign wr_pb  = i_bus.wr && i_bus.addr == `PORT_B_OFS;

    // Request polarity applied after the synchroniser
    assign req_act = s.req_s2 ^ s.cfg.group1_request_invert;

    // Recognition: level, leading edge or trailing edge of the request
    always_comb begin
        recog = 1'b0;
        if ((s.cfg.port_a_handshake_enable || s.cfg.port_b_handshake_enable)
            && !s.cfg.group1_local_reset && s.hs == HS_IDLE) begin
            if (s.cfg.group1_pulse_mode) begin
                if (s.cfg.group1_trailing_edge_select) begin
                    recog = !req_act && s.req_prev;
                end else begin
                    recog = req_act && !s.req_prev;
                end
            end else begin
                recog = req_act;
            end
        end
    end

    // Pattern FIFO is the first buffer of a double-buffered output port
    assign pa_dbl_out = s.cfg.port_a_handshake_enable && s.cfg.port_a_double_buffer
                        && i_port_a_dir_out;
    assign fifo_push  = wr_pa && pa_dbl_out;
    assign fifo_pop   = recog && pa_dbl_out;
    assign o_port_a_wr_ready = fifo_ready;

    hs_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_flush    (s.cfg.group1_local_reset),
        .i_in_valid (fifo_push),
        .i_in_data  (i_bus.wdata[7:0]),
        .o_in_ready (fifo_ready),
        .o_out_valid(fifo_valid),
        .o_out_data (fifo_data),
        .i_out_ready(fifo_pop)
    );

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;
        // Two-stage synchronisers on every pin input
        next_s.req_s1   = i_group1_request_line;
        next_s.req_s2   = s.req_s1;
        next_s.pa_s1    = i_port_a_pins;
        next_s.pa_s2    = s.pa_s1;
        next_s.pb_s1    = i_port_b_pins;
        next_s.pb_s2    = s.pb_s1;
        next_s.req_prev = req_act;

        if (wr_cfg) begin
            next_s.cfg = to_cfg(i_bus.wdata);
        end

        // Output data paths
        if (fifo_pop && fifo_valid) begin
            next_s.pa_out = fifo_data;
        end else if (wr_pa && !pa_dbl_out) begin
            next_s.pa_out = i_bus.wdata[7:0];
        end
        if (wr_pb) begin
            next_s.pb_out = i_bus.wdata[7:0];
        end

        // Input latches on a recognised request
        if (recog && s.cfg.port_a_handshake_enable && s.cfg.port_a_double_buffer
            && !i_port_a_dir_out) begin
            next_s.pa_in = s.pa_s2;
        end
        if (recog && s.cfg.port_b_handshake_enable && !i_port_b_dir_out) begin
            next_s.pb_in = s.pb_s2;
        end

        // Acknowledge sequencer
        case (s.hs)
            HS_IDLE: begin
                if (recog) begin
                    next_s.ack = 1'b1;
                    if (s.cfg.group1_pulse_mode) begin
                        next_s.hs  = HS_ACK_PULSE;
                        next_s.cnt = ACK_CYC - 8'h01;
                    end else begin
                        next_s.hs = HS_ACK_LEVEL;
                    end
                end
            end
            HS_ACK_LEVEL: begin
                // Hold until the peripheral withdraws its request
                if (!req_act) begin
                    next_s.hs  = HS_IDLE;
                    next_s.ack = 1'b0;
                end
            end
            HS_ACK_PULSE: begin
                if (s.cnt == 8'h00) begin
                    next_s.hs  = HS_IDLE;
                    next_s.ack = 1'b0;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            default: begin
                next_s.hs  = HS_IDLE;
                next_s.ack = 1'b0;
            end
        endcase

        // Local reset holds the handshake idle while the bit stays set
        if (s.cfg.group1_local_reset) begin
            next_s.hs       = HS_IDLE;
            next_s.ack      = 1'b0;
            next_s.cnt      = 8'h00;
            next_s.req_prev = 1'b0;
            next_s.pa_in    = `BYTE_RST;
            next_s.pb_in    = `BYTE_RST;
        end

        // Registered acknowledge pin: manual bit ORed in, then polarity
        next_s.ack_line = (next_s.ack || next_s.cfg.group1_manual_acknowledge)
                          ^ next_s.cfg.group1_acknowledge_invert;

        // Read data registered one cycle after the strobe
        next_s.rdata = `RDATA_RST;
        if (i_bus.rd && i_bus.addr == `PORT_A_OFS) begin
            if (i_port_a_dir_out) begin
                next_s.rdata[7:0] = s.pa_out;
            end else if (s.cfg.port_a_handshake_enable && s.cfg.port_a_double_buffer) begin
                next_s.rdata[7:0] = s.pa_in;
            end else begin
                next_s.rdata[7:0] = s.pa_s2;
            end
        end else if (i_bus.rd && i_bus.addr == `PORT_B_OFS) begin
            if (i_port_b_dir_out) begin
                next_s.rdata[7:0] = s.pb_out;
            end else if (s.cfg.port_b_handshake_enable) begin
                next_s.rdata[7:0] = s.pb_in;
            end else begin
                next_s.rdata[7:0] = s.pb_s2;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs from flops, except the output enables, which follow the direction inputs
    assign o_bus_rdata               = s.rdata;
    assign o_port_a_pins             = s.pa_out;
    assign o_port_a_oe               = i_port_a_dir_out;
    assign o_port_b_pins             = s.pb_out;
    assign o_port_b_oe               = i_port_b_dir_out;
    assign o_group1_acknowledge_line = s.ack_line;
    assign o_extra_output_line       = s.cfg.extra_output_line;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    property p_port_b_latch;
        (recog && s.cfg.port_b_handshake_enable && !i_port_b_dir_out)
            |=> s.pb_in == $past(s.pb_s2);
    endproperty
    a_port_b_latch: assert property (p_port_b_latch)
        else $error("port B input not latched on request");

    property p_lreset_idle;
        s.cfg.group1_local_reset |=> (s.hs == HS_IDLE && !s.ack && s.pa_in == `BYTE_RST);
    endproperty
    a_lreset_idle: assert property (p_lreset_idle)
        else $error("handshake not idle under local reset");

    property p_level_polarity;
        (recog && !s.cfg.group1_pulse_mode) |-> (s.req_s2 != s.cfg.group1_request_invert);
    endproperty
    a_level_polarity: assert property (p_level_polarity)
        else $error("level request taken at wrong polarity");

    property p_trailing_edge;
        (recog && s.cfg.group1_pulse_mode && s.cfg.group1_trailing_edge_select)
            |-> (!req_act && $past(req_act));
    endproperty
    a_trailing_edge: assert property (p_trailing_edge)
        else $error("trailing edge mode took a non-trailing edge");

    property p_dbl_out_copy;
        (fifo_pop && fifo_valid) |=> o_port_a_pins == $past(fifo_data);
    endproperty
    a_dbl_out_copy: assert property (p_dbl_out_copy)
        else $error("first buffer not copied to pins on request");

    property p_single_out;
        (wr_pa && !pa_dbl_out && !fifo_pop) |=> o_port_a_pins == $past(i_bus.wdata[7:0]);
    endproperty
    a_single_out: assert property (p_single_out)
        else $error("single buffered write did not reach pins");

    property p_transparent_read;
        (i_bus.rd && i_bus.addr == `PORT_A_OFS && !i_port_a_dir_out
         && !s.cfg.port_a_double_buffer) |=> o_bus_rdata[7:0] == $past(s.pa_s2);
    endproperty
    a_transparent_read: assert property (p_transparent_read)
        else $error("transparent read did not return pins");

    property p_pulse_width;
        (s.hs == HS_IDLE && recog && s.cfg.group1_pulse_mode && !wr_cfg)
            |=> (s.ack && s.hs == HS_ACK_PULSE)[*8];
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("acknowledge pulse ended too early");

    property p_ack_manual;
        (s.cfg.group1_manual_acknowledge && !wr_cfg)
            |=> o_group1_acknowledge_line == !s.cfg.group1_acknowledge_invert;
    endproperty
    a_ack_manual: assert property (p_ack_manual)
        else $error("manual acknowledge level wrong");

    property p_extra_out;
        wr_cfg |=> o_extra_output_line == $past(i_bus.wdata[`BIT_EXTRA_OUT]);
    endproperty
    a_extra_out: assert property (p_extra_out)
        else $error("extra output line does not follow bit 0");

endmodule

// *** bench/periph_model.sv ***
`timescale 1ns/1ps

module periph_model (
    // Clock
    input  wire logic       i_core_clk,
    // Polarity setup, mirrors the card configuration
    input  wire logic       i_req_inv,
    input  wire logic       i_ack_inv,
    // Handshake lines
    input  wire logic       i_ack_line,
    output logic            o_req_line,
    // Data lines towards port A
    output logic [7:0]      o_pins,
    // Results of the last transfer
    output logic            o_timeout,
    output logic [7:0]      o_lat,
    output logic [7:0]      o_width
);
    logic req_act;
    logic ack_on;

    // Polarity applied on the wire side only
    assign o_req_line = req_act ^ i_req_inv;
    assign ack_on     = i_ack_line ^ i_ack_inv;

    // Idle: no request, pins low
    initial begin
        req_act   = 1'b0;
        o_pins    = 8'h00;
        o_timeout = 1'b0;
        o_lat     = 8'h00;
        o_width   = 8'h00;
    end

    // Static pin value for transparent reads
    task automatic set_pins(input logic [7:0] data);
        @(negedge i_core_clk);
        o_pins = data;
    endtask

    // One transfer; a pulse lasts 8 cycles unless ack comes first
    task automatic handshake(input logic pulse, input logic [7:0] data);
        int n;
        int w;
        n = 0;
        w = 0;
        @(negedge i_core_clk);
        o_pins  = data;
        req_act = 1'b1;
        while (!ack_on && n < 60) begin
            @(negedge i_core_clk);
            n = n + 1;
            if (pulse && n == 8)
                req_act = 1'b0;
        end
        o_timeout = (n >= 60);
        o_lat     = n[7:0];
        // Released lines: no pull, so show the inverse rather than stale data
        req_act   = 1'b0;
        o_pins    = ~data;
        while (ack_on && w < 60) begin
            w = w + 1;
            @(negedge i_core_clk);
        end
        o_width = w[7:0];
    endtask
endmodule

// *** bench/tb_group1_handshake_port_control.sv ***
`timescale 1ns/1ps
`include "g1_hs_cfg.svh"

module tb_group1_handshake_port_control
    import g1_hs_pkg::*;
;
    localparam logic [15:0] A_EN  = 16'h0001 << `BIT_A_EN;
    localparam logic [15:0] B_EN  = 16'h0001 << `BIT_B_EN;
    localparam logic [15:0] LRST  = 16'h0001 << `BIT_LRESET;
    localparam logic [15:0] RQINV = 16'h0001 << `BIT_REQ_INV;
    localparam logic [15:0] DBL   = 16'h0001 << `BIT_DBL_BUF;
    localparam logic [15:0] PULSE = 16'h0001 << `BIT_PULSE;
    localparam logic [15:0] TRAIL = 16'h0001 << `BIT_TRAIL;
    localparam logic [15:0] AKINV = 16'h0001 << `BIT_ACK_INV;

    logic        core_clk;
    logic        rst_n;
    bus_req_t    bus_req;
    logic [15:0] bus_rdata;
    logic        wr_ready;
    logic        dir_a;
    logic        dir_b;
    byte_t       pins_a_in;
    byte_t       pins_a_out;
    logic        oe_a;
    byte_t       pins_b_in;
    byte_t       pins_b_out;
    logic        oe_b;
    logic        req_line;
    logic        ack_line;
    logic        extra_line;
    logic        req_inv;
    logic        ack_inv;
    byte_t       drive_a;
    logic        hs_timeout;
    logic [7:0]  hs_lat;
    logic [7:0]  hs_width;
    int          failures;
    int          num_checks;
    int          i;

    // Port A wire: card drives when output, peripheral otherwise
    assign pins_a_in = oe_a ? pins_a_out : drive_a;

    group1_handshake_port_control #(.FIFO_DEPTH(16)) dut (
        .i_core_clk                (core_clk),
        .i_rst_n                   (rst_n),
        .i_bus                     (bus_req),
        .o_bus_rdata               (bus_rdata),
        .o_port_a_wr_ready         (wr_ready),
        .i_port_a_dir_out          (dir_a),
        .i_port_b_dir_out          (dir_b),
        .i_port_a_pins             (pins_a_in),
        .o_port_a_pins             (pins_a_out),
        .o_port_a_oe               (oe_a),
        .i_port_b_pins             (pins_b_in),
        .o_port_b_pins             (pins_b_out),
        .o_port_b_oe               (oe_b),
        .i_group1_request_line     (req_line),
        .o_group1_acknowledge_line (ack_line),
        .o_extra_output_line       (extra_line)
    );

    periph_model periph (
        .i_core_clk (core_clk),
        .i_req_inv  (req_inv),
        .i_ack_inv  (ack_inv),
        .i_ack_line (ack_line),
        .o_req_line (req_line),
        .o_pins     (drive_a),
        .o_timeout  (hs_timeout),
        .o_lat      (hs_lat),
        .o_width    (hs_width)
    );

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Write strobe lasts one edge; one idle cycle lets the effect land
    task automatic wr(input logic [4:0] addr, input logic [15:0] data);
        @(negedge core_clk);
        bus_req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(negedge core_clk);
        bus_req.wr = 1'b0;
        @(negedge core_clk);
    endtask

    // Read data stands for the one cycle after the strobe edge
    task automatic rd_check(input string name, input logic [4:0] addr, input logic [15:0] exp);
        @(negedge core_clk);
        bus_req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge core_clk);
        bus_req.rd = 1'b0;
        check(name, bus_rdata, exp);
    endtask

    // Polarity changes with handshake off, so the switch is never a request
    task automatic set_pol(input logic rq, input logic ak, input logic [15:0] mode);
        wr(`CONFIG_OFS, (rq ? RQINV : 16'h0000) | (ak ? AKINV : 16'h0000));
        req_inv = rq;
        ack_inv = ak;
        repeat (4) @(negedge core_clk);
        wr(`CONFIG_OFS, mode | (rq ? RQINV : 16'h0000) | (ak ? AKINV : 16'h0000));
    endtask

    // Watchdog, well beyond the expected run length
    initial begin
        #200_000;
        failures = failures + 1;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        core_clk   = 1'b0;
        rst_n      = 1'b0;
        bus_req    = '0;
        dir_a      = 1'b0;
        dir_b      = 1'b0;
        pins_b_in  = 8'h00;
        req_inv    = 1'b0;
        ack_inv    = 1'b0;
        failures   = 0;
        num_checks = 0;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        check("ack_after_reset", {15'h0, ack_line}, 16'h0000);
        check("ready_after_reset", {15'h0, wr_ready}, 16'h0001);
        // Static lines, with the unused bit 7 always set
        for (i = 0; i < 8; i++) begin
            wr(`CONFIG_OFS, 16'h0080 | i[15:0]);
            check("extra_line", {15'h0, extra_line}, {15'h0, i[0]});
            check("ack_static", {15'h0, ack_line}, {15'h0, i[1] ^ i[2]});
        end
        rd_check("cfg_read", `CONFIG_OFS, 16'h0000);
        // Single buffer out on both ports, transparent in on port A
        dir_a = 1'b1;
        dir_b = 1'b1;
        wr(`CONFIG_OFS, 16'h0000);
        wr(`PORT_A_OFS, 16'h005A);
        check("pins_single", {8'h00, pins_a_out}, 16'h005A);
        check("oe_a", {15'h0, oe_a}, 16'h0001);
        wr(`PORT_B_OFS, 16'h00C3);
        check("pins_b", {8'h00, pins_b_out}, 16'h00C3);
        check("oe_b", {15'h0, oe_b}, 16'h0001);
        rd_check("port_b_out", `PORT_B_OFS, 16'h00C3);
        dir_a = 1'b0;
        dir_b = 1'b0;
        periph.set_pins(8'h3C);
        repeat (4) @(negedge core_clk);
        check("oe_a_in", {15'h0, oe_a}, 16'h0000);
        rd_check("port_a_live", `PORT_A_OFS, 16'h003C);
        // Level handshakes over all polarity pairs, latching A and B
        for (i = 0; i < 4; i++) begin
            set_pol(i[0], i[1], A_EN | B_EN | DBL);
            pins_b_in = 8'hC0 + i[7:0];
            periph.handshake(1'b0, 8'hA0 + i[7:0]);
            check("hs_level_done", {15'h0, hs_timeout}, 16'h0000);
            pins_b_in = ~pins_b_in;
            repeat (4) @(negedge core_clk);
            check("ack_idle", {15'h0, ack_line}, {15'h0, i[1]});
            rd_check("port_a_latch", `PORT_A_OFS, 16'h00A0 + i[15:0]);
            rd_check("port_b_latch", `PORT_B_OFS, 16'h00C0 + i[15:0]);
        end
        // Pattern output: fill the buffer, then one word per pulse
        dir_a = 1'b1;
        set_pol(1'b0, 1'b0, A_EN | DBL | PULSE);
        for (i = 0; i < 16; i++)
            wr(`PORT_A_OFS, 16'h0010 + i[15:0]);
        check("ready_full", {15'h0, wr_ready}, 16'h0000);
        wr(`PORT_A_OFS, 16'h00EE);
        check("pins_held", {8'h00, pins_a_out}, 16'h005A);
        for (i = 0; i < 16; i++) begin
            if (i == 8)
                wr(`CONFIG_OFS, A_EN | DBL | PULSE | TRAIL);
            periph.handshake(1'b1, 8'h00);
            check("pins_word", {8'h00, pins_a_out}, 16'h0010 + i[15:0]);
            check("ack_width", {8'h00, hs_width}, 16'h0014);
            check("edge_pick", {15'h0, (i < 8) ? (hs_lat < 8) : (hs_lat > 8)}, 16'h0001);
        end
        check("ready_drained", {15'h0, wr_ready}, 16'h0001);
        periph.handshake(1'b1, 8'h00);
        check("empty_ack", {15'h0, hs_timeout}, 16'h0000);
        check("pins_empty", {8'h00, pins_a_out}, 16'h001F);
        // Local reset clears the latch and blocks requests
        dir_a = 1'b0;
        wr(`CONFIG_OFS, A_EN | DBL);
        periph.handshake(1'b0, 8'h77);
        wr(`CONFIG_OFS, A_EN | DBL | LRST);
        rd_check("latch_in_reset", `PORT_A_OFS, 16'h0000);
        periph.handshake(1'b0, 8'h66);
        check("no_ack_in_reset", {15'h0, hs_timeout}, 16'h0001);
        wr(`CONFIG_OFS, 16'h0000);
        wr(`CONFIG_OFS, A_EN | DBL);
        periph.handshake(1'b0, 8'h99);
        check("hs_after_reset", {15'h0, hs_timeout}, 16'h0000);
        repeat (4) @(negedge core_clk);
        rd_check("latch_after_reset", `PORT_A_OFS, 16'h0099);
        tally_and_finish();
    end
endmodule
